// File: ras_core_model.sv
// Core sequencer model: program counter, context registers and fault reset feedback
`timescale 1ns/1ps
module ras_core_model
    import ras_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic set_en,
    input wire logic [RAS_PC_W-1:0] set_pc,
    input wire logic [3*RAS_DATA_W-1:0] set_ctx,
    input wire logic pc_load,
    input wire logic [RAS_PC_W-1:0] pc_ret,
    input wire logic fast_restore,
    input wire logic [3*RAS_DATA_W-1:0] ctx_ret,
    input wire logic fault_reset,
    output logic [RAS_PC_W-1:0] pc_r,
    output logic [3*RAS_DATA_W-1:0] ctx_r,
    output logic device_reset
);
    // Fault request comes back as a device reset, as the real reset path does
    assign device_reset = fault_reset;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pc_r <= RAS_PC_ZERO;
        end else if (pc_load) begin
            pc_r <= pc_ret;
        end else if (set_en) begin
            pc_r <= set_pc;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ctx_r <= 24'h00_0000;
        end else if (fast_restore) begin
            ctx_r <= ctx_ret;
        end else if (set_en) begin
            ctx_r <= set_ctx;
        end
    end
endmodule

// File: ras_pkg.sv
// Constants, register map and field layout of the return address stack
package ras_pkg;
    localparam int RAS_PC_W = 21;
    localparam int RAS_PTR_W = 5;
    localparam int RAS_DEPTH = 31;
    localparam int RAS_ADDR_W = 4;
    localparam int RAS_DATA_W = 8;
    localparam int RAS_UPPER_W = RAS_PC_W - 16;

    localparam logic [RAS_PTR_W-1:0] RAS_PTR_EMPTY = 5'h00;
    localparam logic [RAS_PTR_W-1:0] RAS_PTR_LAST = 5'h1E;
    localparam logic [RAS_PTR_W-1:0] RAS_PTR_FULL = 5'h1F;
    localparam logic [RAS_PTR_W-1:0] RAS_PTR_STEP = 5'h01;
    localparam logic [RAS_PC_W-1:0] RAS_PC_STEP = 21'h0_0002;
    localparam logic [RAS_PC_W-1:0] RAS_PC_ZERO = 21'h0_0000;

    localparam logic [RAS_ADDR_W-1:0] RAS_OFS_PTR_STATUS = 4'h0;
    localparam logic [RAS_ADDR_W-1:0] RAS_OFS_TOP_LOW = 4'h1;
    localparam logic [RAS_ADDR_W-1:0] RAS_OFS_TOP_HIGH = 4'h2;
    localparam logic [RAS_ADDR_W-1:0] RAS_OFS_TOP_UPPER = 4'h3;

    localparam int RAS_BIT_FULL = 7;
    localparam int RAS_BIT_UNDERFLOW = 6;
    localparam int RAS_PTR_LSB = 0;

    localparam logic [RAS_DATA_W-1:0] RAS_RST_BYTE = 8'h00;
    localparam logic [RAS_DATA_W-1:0] RAS_RST_STATUS = 8'h00;
endpackage

// File: ras_return_stack.sv
// Return address stack with pointer, sticky flags and one-level fast register stack
// How it works
// - Thirty-one 21-bit entries behind a 5-bit pointer, outside program and data space.
// - Calls, relative calls and interrupt acknowledges push the program counter.
// - Plain return, return with literal and return from interrupt pop the counter.
// - Push increments the pointer first, then writes the counter into that entry.
// - Pop moves the addressed entry to the counter, then decrements the pointer.
// - Calls and returns never touch the upper and high counter latches.
// - Every reset zeroes the pointer; pointer zero has no entry behind it.
// - Top-entry byte registers read and write the entry the pointer addresses.
// - Software reads and writes the pointer, any value zero to thirty-one.
// - Full flag sets after thirty-one pushes; only software or power-on clears it.
// - Fault reset enabled: thirty-first push stores counter plus two, flags, resets, zeroes pointer.
// - Fault reset disabled: pointer reaches thirty-one; further pushes neither write nor move.
// - Pop when empty loads zero, sets sticky underflow, pointer stays zero.
// - Full or underflow sets its flag, and resets the device only when enabled.
// - Fault reset disabled: underflow vectoring to zero is no reset; other registers keep their contents.
// - Explicit push increments the pointer and stores the current counter.
// - Explicit pop only decrements the pointer, exposing the previous entry.
// - Any interrupt vectoring loads hidden shadows of status, working and bank select.
// - Fast return from interrupt copies the shadows back.
// - Fast call saves into the shadows; fast return restores from them.
// - A nested interrupt overwrites the shadows of the one it interrupted.
// - Status register: full bit 7, underflow bit 6, clear-only; bit 5 zero; pointer bits 4..0.
`timescale 1ns/1ps
module ras_return_stack
    import ras_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic DEVICE_RESET,
    input wire logic STACK_FAULT_RESET_ENABLE,
    input wire logic CALL_PUSH,
    input wire logic INT_ACK,
    input wire logic PUSH_INSTR,
    input wire logic RETURN_POP,
    input wire logic POP_INSTR,
    input wire logic FAST_OPTION,
    input wire logic [RAS_PC_W-1:0] PC_IN,
    input wire logic [RAS_DATA_W-1:0] STATUS_IN,
    input wire logic [RAS_DATA_W-1:0] WORKING_REGISTER_IN,
    input wire logic [RAS_DATA_W-1:0] BANK_SELECT_REGISTER_IN,
    output logic [RAS_PC_W-1:0] PC_OUT,
    output logic PC_LOAD,
    output logic FAST_RESTORE,
    output logic [RAS_DATA_W-1:0] STATUS_OUT,
    output logic [RAS_DATA_W-1:0] WORKING_REGISTER_OUT,
    output logic [RAS_DATA_W-1:0] BANK_SELECT_REGISTER_OUT,
    output logic STACK_FAULT_RESET,
    input wire logic [RAS_ADDR_W-1:0] REG_ADDR,
    input wire logic [RAS_DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [RAS_DATA_W-1:0] REG_RDATA
);

    // Entry zero is never built: pointer zero only means empty
    logic [RAS_PC_W-1:0] stack_mem [1:RAS_DEPTH];

    logic [RAS_PTR_W-1:0] ptr_r;
    logic [RAS_PTR_W-1:0] ptr_nxt;
    logic full_r;
    logic underflow_r;
    logic [RAS_DATA_W-1:0] shadow_status_r;
    logic [RAS_DATA_W-1:0] shadow_working_r;
    logic [RAS_DATA_W-1:0] shadow_bank_r;

    logic push_req;
    logic pop_req;
    logic stack_empty;
    logic at_last;
    logic at_top;
    logic push_store;
    logic overflow_reset;
    logic underflow_hit;
    logic fault_reset;
    logic [RAS_PTR_W-1:0] ptr_inc;
    logic [RAS_PTR_W-1:0] ptr_dec;
    logic [RAS_PC_W-1:0] push_value;
    logic [RAS_PC_W-1:0] top_entry;
    logic wr_status;
    logic wr_top_low;
    logic wr_top_high;
    logic wr_top_upper;
    logic wr_top_any;
    logic shadow_load;
    logic shadow_restore;

    // Command decode; the core issues one stack command per cycle, push taking priority
    assign push_req = CALL_PUSH | INT_ACK | PUSH_INSTR;
    assign pop_req = ~push_req & (RETURN_POP | POP_INSTR);

    assign stack_empty = (ptr_r == RAS_PTR_EMPTY);
    assign at_last = (ptr_r == RAS_PTR_LAST);
    assign at_top = (ptr_r == RAS_PTR_FULL);
    assign ptr_inc = ptr_r + RAS_PTR_STEP;
    assign ptr_dec = ptr_r - RAS_PTR_STEP;

    assign top_entry = stack_empty ? RAS_PC_ZERO : stack_mem[ptr_r];

    // Once the pointer sits at the top a push writes nothing more
    assign push_store = push_req & ~at_top;
    assign overflow_reset = push_req & STACK_FAULT_RESET_ENABLE & (at_last | at_top);
    assign underflow_hit = pop_req & stack_empty;
    assign fault_reset = overflow_reset | (underflow_hit & STACK_FAULT_RESET_ENABLE);

    // Faulting thirty-first push stores the address after the call so the handler can find it
    assign push_value = (at_last & STACK_FAULT_RESET_ENABLE) ? PC_IN + RAS_PC_STEP : PC_IN;

    assign wr_status = REG_WR & (REG_ADDR == RAS_OFS_PTR_STATUS);
    assign wr_top_low = REG_WR & (REG_ADDR == RAS_OFS_TOP_LOW);
    assign wr_top_high = REG_WR & (REG_ADDR == RAS_OFS_TOP_HIGH);
    assign wr_top_upper = REG_WR & (REG_ADDR == RAS_OFS_TOP_UPPER);
    assign wr_top_any = wr_top_low | wr_top_high | wr_top_upper;

    assign shadow_load = INT_ACK | (CALL_PUSH & FAST_OPTION);
    assign shadow_restore = RETURN_POP & FAST_OPTION & ~push_req;

    // Pointer next value; core commands beat a software pointer write in the same cycle
    always_comb begin
        ptr_nxt = ptr_r;
        if (DEVICE_RESET) begin
            ptr_nxt = RAS_PTR_EMPTY;
        end else if (push_req) begin
            if (overflow_reset) begin
                ptr_nxt = RAS_PTR_EMPTY;
            end else if (at_top) begin
                ptr_nxt = RAS_PTR_FULL;
            end else begin
                ptr_nxt = ptr_inc;
            end
        end else if (pop_req) begin
            if (stack_empty) begin
                ptr_nxt = RAS_PTR_EMPTY;
            end else begin
                ptr_nxt = ptr_dec;
            end
        end else if (wr_status) begin
            ptr_nxt = REG_WDATA[RAS_PTR_LSB +: RAS_PTR_W];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            ptr_r <= RAS_PTR_EMPTY;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // Sticky flags: only power-on reset or a software zero clears them, and a new event wins
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            full_r <= 1'b0;
        end else if (push_req & (at_last | at_top)) begin
            full_r <= 1'b1;
        end else if (wr_status & ~REG_WDATA[RAS_BIT_FULL]) begin
            full_r <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            underflow_r <= 1'b0;
        end else if (underflow_hit) begin
            underflow_r <= 1'b1;
        end else if (wr_status & ~REG_WDATA[RAS_BIT_UNDERFLOW]) begin
            underflow_r <= 1'b0;
        end
    end

    // Stack RAM has no reset; a push drops a top-entry write arriving in the same cycle
    // Any push refuses the write, even a refused push at the top that stores nothing
    always_ff @(posedge CLOCK) begin
        if (push_store & ~DEVICE_RESET) begin
            stack_mem[ptr_inc] <= push_value;
        end else if (wr_top_any & ~stack_empty & ~pop_req & ~push_req) begin
            if (wr_top_low) begin
                stack_mem[ptr_r][7:0] <= REG_WDATA;
            end
            if (wr_top_high) begin
                stack_mem[ptr_r][15:8] <= REG_WDATA;
            end
            if (wr_top_upper) begin
                stack_mem[ptr_r][RAS_PC_W-1:16] <= REG_WDATA[RAS_UPPER_W-1:0];
            end
        end
    end

    // Return path drives only the counter itself, never its latch registers
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            PC_OUT <= RAS_PC_ZERO;
            PC_LOAD <= 1'b0;
        end else begin
            PC_LOAD <= RETURN_POP & ~push_req;
            if (RETURN_POP & ~push_req) begin
                // Empty stack returns zero, vectoring without a reset unless fault reset is enabled
                PC_OUT <= top_entry;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            STACK_FAULT_RESET <= 1'b0;
        end else begin
            STACK_FAULT_RESET <= fault_reset & ~DEVICE_RESET;
        end
    end

    // Shadows are hidden from software; later interrupts simply overwrite them
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            shadow_status_r <= RAS_RST_BYTE;
            shadow_working_r <= RAS_RST_BYTE;
            shadow_bank_r <= RAS_RST_BYTE;
        end else if (shadow_load) begin
            shadow_status_r <= STATUS_IN;
            shadow_working_r <= WORKING_REGISTER_IN;
            shadow_bank_r <= BANK_SELECT_REGISTER_IN;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            FAST_RESTORE <= 1'b0;
            STATUS_OUT <= RAS_RST_BYTE;
            WORKING_REGISTER_OUT <= RAS_RST_BYTE;
            BANK_SELECT_REGISTER_OUT <= RAS_RST_BYTE;
        end else begin
            FAST_RESTORE <= shadow_restore;
            if (shadow_restore) begin
                STATUS_OUT <= shadow_status_r;
                WORKING_REGISTER_OUT <= shadow_working_r;
                BANK_SELECT_REGISTER_OUT <= shadow_bank_r;
            end
        end
    end

    // Read data stand one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            REG_RDATA <= RAS_RST_BYTE;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                RAS_OFS_PTR_STATUS: begin
                    REG_RDATA <= {full_r, underflow_r, 1'b0, ptr_r};
                end
                RAS_OFS_TOP_LOW: begin
                    REG_RDATA <= top_entry[7:0];
                end
                RAS_OFS_TOP_HIGH: begin
                    REG_RDATA <= top_entry[15:8];
                end
                RAS_OFS_TOP_UPPER: begin
                    REG_RDATA <= {3'h0, top_entry[RAS_PC_W-1:16]};
                end
                default: begin
                    REG_RDATA <= RAS_RST_BYTE;
                end
            endcase
        end else begin
            REG_RDATA <= RAS_RST_BYTE;
        end
    end

    // Checks share the core clock; power-on reset masks them
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    push_incr_a: assert property (
        (push_req && !DEVICE_RESET && ptr_r < RAS_PTR_LAST)
        |=> (ptr_r == $past(ptr_inc)) && (top_entry == $past(PC_IN))
    ) else $error("push did not advance pointer and store counter");

    pop_move_a: assert property (
        (RETURN_POP && !push_req && !DEVICE_RESET && !stack_empty)
        |=> PC_LOAD && (PC_OUT == $past(top_entry)) && (ptr_r == $past(ptr_dec))
    ) else $error("return did not load top entry and decrement");

    pop_empty_a: assert property (
        (RETURN_POP && !push_req && !DEVICE_RESET && stack_empty)
        |=> (PC_OUT == RAS_PC_ZERO) && underflow_r && (ptr_r == RAS_PTR_EMPTY)
    ) else $error("empty return mishandled");

    full_hold_a: assert property (
        (push_req && at_top && !STACK_FAULT_RESET_ENABLE && !DEVICE_RESET)
        |=> (ptr_r == RAS_PTR_FULL) && full_r && (top_entry == $past(top_entry))
    ) else $error("push beyond full moved pointer or overwrote entry");

    full_fault_a: assert property (
        (push_req && at_last && STACK_FAULT_RESET_ENABLE && !DEVICE_RESET)
        |=> STACK_FAULT_RESET && full_r && (ptr_r == RAS_PTR_EMPTY)
            && (stack_mem[RAS_PTR_FULL] == $past(PC_IN) + RAS_PC_STEP)
    ) else $error("thirty-first push with fault reset mishandled");

    flag_sticky_a: assert property (
        full_r && !(wr_status && !REG_WDATA[RAS_BIT_FULL]) |=> full_r
    ) else $error("full flag dropped without a software clear");

    no_fault_a: assert property (
        !STACK_FAULT_RESET_ENABLE |=> !STACK_FAULT_RESET
    ) else $error("fault reset raised while disabled");

    ptr_reset_a: assert property (
        DEVICE_RESET |=> (ptr_r == RAS_PTR_EMPTY)
    ) else $error("pointer not zeroed by reset");

    shadow_trip_a: assert property (
        (INT_ACK ##1 (!shadow_load)[*3] ##0 shadow_restore)
        |=> FAST_RESTORE && (STATUS_OUT == $past(STATUS_IN, 4))
            && (BANK_SELECT_REGISTER_OUT == $past(BANK_SELECT_REGISTER_IN, 4))
    ) else $error("fast return did not restore saved context");

    status_read_a: assert property (
        (REG_RD && REG_ADDR == RAS_OFS_PTR_STATUS)
        |=> (REG_RDATA[5] == 1'b0) && (REG_RDATA[4:0] == $past(ptr_r))
            && (REG_RDATA[RAS_BIT_FULL] == $past(full_r))
    ) else $error("status read layout wrong");

    // Flags and pointer side effects seen from software
    underflow_sticky_a: assert property (
        underflow_r && !(wr_status && !REG_WDATA[RAS_BIT_UNDERFLOW]) |=> underflow_r
    ) else $error("underflow flag dropped without a software clear");

    full_set_a: assert property (
        (push_req && at_last && !STACK_FAULT_RESET_ENABLE && !DEVICE_RESET)
        |=> full_r && (ptr_r == RAS_PTR_FULL) && (top_entry == $past(PC_IN))
    ) else $error("thirty-first push did not fill the stack");

    full_clear_a: assert property (
        (wr_status && !REG_WDATA[RAS_BIT_FULL] && !(push_req && (at_last || at_top)))
        |=> !full_r
    ) else $error("software clear of full flag ignored");

    underflow_fault_a: assert property (
        (pop_req && stack_empty && STACK_FAULT_RESET_ENABLE && !DEVICE_RESET)
        |=> STACK_FAULT_RESET && underflow_r
    ) else $error("empty pop with fault reset did not request reset");

    pop_instr_a: assert property (
        (POP_INSTR && !RETURN_POP && !push_req && !stack_empty && !DEVICE_RESET)
        |=> !PC_LOAD && (ptr_r == $past(ptr_dec))
    ) else $error("pop instruction loaded counter or missed decrement");

    ptr_write_a: assert property (
        (wr_status && !push_req && !pop_req && !DEVICE_RESET)
        |=> (ptr_r == $past(REG_WDATA[RAS_PTR_LSB +: RAS_PTR_W]))
    ) else $error("software pointer write lost");

    top_write_a: assert property (
        (wr_top_low && !stack_empty && !push_req && !pop_req && !DEVICE_RESET)
        |=> (top_entry[7:0] == $past(REG_WDATA))
    ) else $error("top entry low byte write lost");

    // Shadow capture on every interrupt and on a fast call
    shadow_load_a: assert property (
        INT_ACK
        |=> (shadow_status_r == $past(STATUS_IN)) && (shadow_working_r == $past(WORKING_REGISTER_IN))
            && (shadow_bank_r == $past(BANK_SELECT_REGISTER_IN))
    ) else $error("interrupt did not capture context");

    fast_call_a: assert property (
        (CALL_PUSH && FAST_OPTION)
        |=> (shadow_status_r == $past(STATUS_IN)) && (shadow_working_r == $past(WORKING_REGISTER_IN))
            && (shadow_bank_r == $past(BANK_SELECT_REGISTER_IN))
    ) else $error("fast call did not capture context");

    rdata_idle_a: assert property (
        !REG_RD |=> (REG_RDATA == RAS_RST_BYTE)
    ) else $error("read data stood outside the read cycle");

endmodule

// File: return_address_stack_bench.sv
// Self-checking bench for the return address stack
`timescale 1ns/1ps
module return_address_stack_bench;
    import ras_pkg::*;
    logic CLOCK = 1'b0;
    logic RESET_N = 1'b0;
    logic fault_en = 1'b0, call_p = 1'b0, int_ack = 1'b0, push_i = 1'b0, ret_p = 1'b0, pop_i = 1'b0, fast = 1'b0;
    logic set_en = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, dev_rst, pc_load, fast_rst, fault_rst;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [20:0] set_pc = 21'h0_0000, pc, pc_out, stk [32];
    logic [23:0] set_ctx = 24'h00_0000, ctx, shd = 24'h00_0000;
    wire [23:0] ctx_out;
    logic [4:0] e_ptr = 5'h00;
    logic e_full = 1'b0, e_unf = 1'b0;
    logic [15:0] lf = 16'h0030;
    int miscompares = 0, samples_checked = 0, i;

    always #2 CLOCK = ~CLOCK;

    ras_return_stack i_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .DEVICE_RESET(dev_rst),
        .STACK_FAULT_RESET_ENABLE(fault_en), .CALL_PUSH(call_p), .INT_ACK(int_ack), .PUSH_INSTR(push_i),
        .RETURN_POP(ret_p), .POP_INSTR(pop_i), .FAST_OPTION(fast), .PC_IN(pc), .STATUS_IN(ctx[23:16]),
        .WORKING_REGISTER_IN(ctx[15:8]), .BANK_SELECT_REGISTER_IN(ctx[7:0]), .PC_OUT(pc_out),
        .PC_LOAD(pc_load), .FAST_RESTORE(fast_rst), .STATUS_OUT(ctx_out[23:16]),
        .WORKING_REGISTER_OUT(ctx_out[15:8]), .BANK_SELECT_REGISTER_OUT(ctx_out[7:0]),
        .STACK_FAULT_RESET(fault_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

    ras_core_model i_core (.clock(CLOCK), .reset_n(RESET_N), .set_en(set_en), .set_pc(set_pc),
        .set_ctx(set_ctx), .pc_load(pc_load), .pc_ret(pc_out), .fast_restore(fast_rst), .ctx_ret(ctx_out),
        .fault_reset(fault_rst), .pc_r(pc), .ctx_r(ctx), .device_reset(dev_rst));

    function automatic logic [20:0] rnd();
        logic [4:0] hi;
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        hi = lf[4:0];
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return {hi, lf};
    endfunction

    function automatic logic [7:0] exp_status();
        return {e_full, e_unf, 1'b0, e_ptr};
    endfunction

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLOCK);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge CLOCK);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge CLOCK);
        reg_wr <= 1'b0;
        if (a == RAS_OFS_PTR_STATUS) begin
            e_full &= d[7];
            e_unf &= d[6];
            e_ptr = d[4:0];
        end else if (e_ptr != RAS_PTR_EMPTY) begin
            if (a == RAS_OFS_TOP_LOW) stk[e_ptr][7:0] = d;
            if (a == RAS_OFS_TOP_HIGH) stk[e_ptr][15:8] = d;
            if (a == RAS_OFS_TOP_UPPER) stk[e_ptr][20:16] = d[4:0];
        end
    endtask

    task automatic top_chk();
        rd(RAS_OFS_PTR_STATUS, exp_status());
        if (e_ptr != RAS_PTR_EMPTY) begin
            rd(RAS_OFS_TOP_LOW, stk[e_ptr][7:0]);
            rd(RAS_OFS_TOP_HIGH, stk[e_ptr][15:8]);
            rd(RAS_OFS_TOP_UPPER, {3'b000, stk[e_ptr][20:16]});
        end
    endtask

    // Sources: 0 call, 1 interrupt, 2 push instruction, 3 return, 4 pop instruction
    task automatic cmd(input int src, input logic [20:0] v, input logic [23:0] c, input logic f);
        logic [20:0] e_pc;
        logic e_flt;
        e_pc = RAS_PC_ZERO;
        e_flt = 1'b0;
        @(posedge CLOCK);
        set_en <= 1'b1;
        set_pc <= v;
        set_ctx <= c;
        @(posedge CLOCK);
        set_en <= 1'b0;
        {call_p, int_ack, push_i, ret_p, pop_i, fast} <= {src == 0, src == 1, src == 2, src == 3, src == 4, f};
        @(posedge CLOCK);
        {call_p, int_ack, push_i, ret_p, pop_i, fast} <= 6'h00;
        if (src < 3) begin
            e_flt = fault_en && (e_ptr == RAS_PTR_FULL || e_ptr == RAS_PTR_LAST);
            if (e_ptr == RAS_PTR_FULL) begin
                e_full = 1'b1;
                if (e_flt) e_ptr = RAS_PTR_EMPTY;
            end else if (e_flt) begin
                stk[31] = v + RAS_PC_STEP;
                e_full = 1'b1;
                e_ptr = RAS_PTR_EMPTY;
            end else begin
                e_ptr++;
                stk[e_ptr] = v;
                e_full |= (e_ptr == RAS_PTR_FULL);
            end
            if (src == 1 || (src == 0 && f)) shd = c;
        end else if (e_ptr == RAS_PTR_EMPTY) begin
            e_unf = 1'b1;
            e_flt = fault_en;
        end else begin
            e_pc = stk[e_ptr];
            e_ptr--;
        end
        #1 chk("pc_load", src == 3, pc_load);
        if (src == 3) chk("pc_out", e_pc, pc_out);
        chk("fault_reset", e_flt, fault_rst);
        chk("fast_restore", src == 3 && f, fast_rst);
        if (src == 3 && f) chk("shadow_out", shd, ctx_out);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run needs under five hundred cycles; this bounds a hang
    initial begin
        repeat (20000) @(posedge CLOCK);
        miscompares++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge CLOCK);
        RESET_N <= 1'b1;
        rd(RAS_OFS_PTR_STATUS, 8'h00);
        rd(4'h9, 8'h00);
        for (i = 0; i < 12; i++) begin
            cmd(i % 3, rnd(), {3'b000, rnd()}, 1'b0);
            top_chk();
        end
        for (i = 0; i < 6; i++) begin
            cmd(3 + i % 2, rnd(), 24'h00_0000, 1'b0);
            top_chk();
        end
        while (e_ptr != RAS_PTR_FULL) cmd(0, rnd(), 24'h00_0000, 1'b0);
        top_chk();
        for (i = 0; i < 2; i++) cmd(i, rnd(), 24'h00_0000, 1'b0);
        top_chk();
        wr(RAS_OFS_PTR_STATUS, 8'h3F);
        for (i = 0; i < 8; i++) begin
            wr(RAS_OFS_PTR_STATUS, {3'b000, lf[4:0]});
            wr(4'(i % 3 + 1), lf[15:8]);
            top_chk();
            lf = 16'(rnd());
        end
        wr(RAS_OFS_PTR_STATUS, 8'h00);
        cmd(3, rnd(), 24'h00_0000, 1'b0);
        fault_en <= 1'b1;
        cmd(4, rnd(), 24'h00_0000, 1'b0);
        rd(RAS_OFS_PTR_STATUS, 8'h40);
        wr(RAS_OFS_PTR_STATUS, 8'h45);
        top_chk();
        wr(RAS_OFS_PTR_STATUS, 8'h1E);
        cmd(2, rnd(), 24'h00_0000, 1'b0);
        top_chk();
        wr(RAS_OFS_PTR_STATUS, 8'h9F);
        top_chk();
        fault_en <= 1'b0;
        cmd(0, rnd(), 24'hA5_5AC3, 1'b1);
        cmd(3, rnd(), 24'h11_2233, 1'b1);
        cmd(1, rnd(), 24'h0F_F001, 1'b0);
        cmd(1, rnd(), 24'h3C_C30E, 1'b0);
        cmd(3, rnd(), 24'h00_0000, 1'b1);
        @(posedge CLOCK);
        #1 chk("core_ctx", shd, ctx);
        close_out();
    end
endmodule
